// ### hw/dcwd_consts.vh
// dcwd_consts.vh: bit positions, telegram codes and reset values for the drive control word decoder
// assumes: included by its bare name from the decoder's design files
`ifndef DCWD_CONSTS_VH
`define DCWD_CONSTS_VH
// =============================================
// control word bit positions
`define DCWD_BIT_RAMP_STOP     0
`define DCWD_BIT_COAST_STOP    1
`define DCWD_BIT_FAST_STOP     2
`define DCWD_BIT_ENABLE_OP     3
`define DCWD_BIT_RAMP_ENABLE   4
`define DCWD_BIT_RAMP_RUN      5
`define DCWD_BIT_SETP_ENABLE   6
`define DCWD_BIT_FAULT_ACK     7
`define DCWD_BIT_HOST_CTRL     10
`define DCWD_BIT_POT_RAISE     13
`define DCWD_BIT_POT_LOWER     14
`define DCWD_BIT_CMD_SET0      15
// =============================================
// telegram selector codes
`define DCWD_TEL_STD           10'h001
`define DCWD_TEL_NAMUR         10'h014
`define DCWD_TEL_PCS           10'h160
`define DCWD_TEL_FREE          10'h3e7
// =============================================
// setpoint scaling: word 16'h4000 equals reference speed
`define DCWD_SCALE_SHIFT       14
// =============================================
// reset values
`define DCWD_RST_WORD          16'h0000
`define DCWD_RST_SPEED         16'h0000
`define DCWD_RST_POT           16'h0000
// word used in place of the bus word while host control is off:
// coast and fast stops released, ramp stop held by bit0 low, nothing switched on
`define DCWD_IDLE_WORD         16'h0006
`endif

// ### hw/dcwd_word_reg.v
// dcwd_word_reg.v: one received process data word, held in a register
// assumes: same clock as the decoder; load is a one-cycle strobe
`include "dcwd_consts.vh"

module dcwd_word_reg (
    // clock and reset
    input  wire        clk_sys,
    input  wire        reset,
    // load side
    input  wire        load,
    input  wire [15:0] din,
    // held word
    output reg  [15:0] dout
);
    // =============================================
    // storage
    // reload on strobe, clear on reset
    always @(posedge clk_sys) begin
        if (reset) begin
            dout <= `DCWD_RST_WORD;
        end else if (load) begin
            dout <= din;
        end
    end
endmodule // dcwd_word_reg

// ### hw/dcwd_decoder.v
// dcwd_decoder.v: decodes the cyclic drive control word and speed setpoint word
// assumes: words arrive as a valid-qualified pair from logic on clk_sys;
// selector and source inputs are logic on clk_sys; reference speed is static
`include "dcwd_consts.vh"

module dcwd_decoder (
    // clock and reset
    input  wire               clk_sys,
    input  wire               reset,
    // received process data words
    input  wire               pd_valid,
    input  wire [15:0]        pd_word1,
    input  wire [15:0]        pd_word2,
    // configuration
    input  wire [9:0]         telegram_selector,
    input  wire [15:0]        reference_speed,
    // second sources for stop, acknowledge and host control
    input  wire               coast_stop_source_b,
    input  wire               fast_stop_source_b,
    input  wire               fault_ack_source_b,
    input  wire               fault_ack_source_c,
    input  wire               host_control_source,
    // decoded stop commands and switch-on edge, active high
    output reg                ramp_stop_command,
    output reg                coast_stop_command,
    output reg                fast_stop_command,
    output reg                switch_on_edge,
    // pulse and contactor
    output reg                pulse_enable,
    output reg                contactor_close,
    output reg                ready_for_operation,
    // ramp generator controls
    output reg                ramp_force_zero,
    output reg                ramp_freeze,
    output reg                ramp_input_zero,
    output reg signed [15:0]  ramp_setpoint,
    output reg signed [31:0]  speed_scaled,
    // other decoded commands
    output reg                fault_ack,
    output reg                pot_raise,
    output reg                pot_lower,
    output reg                pot_freeze,
    output reg                command_set_select,
    output reg                host_control_active
);
    // =============================================
    // held words
    wire [15:0] drive_control_word;   // word one of the telegram
    wire [15:0] speed_setpoint_word;  // word two of the telegram

    // both words load on the same valid edge, so the pair never splits
    // and a control word is never applied with a stale setpoint
    // word one always carries the control word in every layout
    dcwd_word_reg u_ctrl (
        .clk_sys (clk_sys),
        .reset   (reset),
        .load    (pd_valid),
        .din     (pd_word1),
        .dout    (drive_control_word)
    );

    // word two carries the setpoint in fixed layouts, and by default in the free one
    dcwd_word_reg u_speed (
        .clk_sys (clk_sys),
        .reset   (reset),
        .load    (pd_valid),
        .din     (pd_word2),
        .dout    (speed_setpoint_word)
    );

    // =============================================
    // telegram decode
    // the selector is a static level, so a plain compare is enough;
    // an unknown code matches none and leaves every optional bit reserved
    wire tel_std;   // telegram 1
    wire tel_namur; // telegram 20
    wire tel_pcs;   // telegram 352
    assign tel_std   = (telegram_selector == `DCWD_TEL_STD);
    assign tel_namur = (telegram_selector == `DCWD_TEL_NAMUR);
    assign tel_pcs   = (telegram_selector == `DCWD_TEL_PCS);

    // =============================================
    // host control gating
    // bus words count only while bit10 and the host source are both high
    // hazard: dropping the gate must not leave old commands in force,
    // so the word is swapped for a safe idle word, not held
    wire host_ok;
    assign host_ok = drive_control_word[`DCWD_BIT_HOST_CTRL] & host_control_source;

    // safe default word while the bus is ignored: coast and fast stops released, ramp stop held, nothing enabled
    // the master is trusted to raise bit10 only after readiness
    wire [15:0] cw;
    assign cw = host_ok ? drive_control_word : `DCWD_IDLE_WORD;
    wire signed [15:0] spd;
    assign spd = host_ok ? speed_setpoint_word : `DCWD_RST_SPEED;

    // =============================================
    // stop sources, each active low
    wire coast_ok;  // high means no coast stop
    wire fast_ok;   // high means no fast stop
    assign coast_ok = cw[`DCWD_BIT_COAST_STOP] & coast_stop_source_b;
    assign fast_ok  = cw[`DCWD_BIT_FAST_STOP]  & fast_stop_source_b;

    // stop priority: coast over fast over ramp
    // at most one stop is reported at a time, so the consumer never
    // has to arbitrate between two ramps while pulses are going off
    wire coast_act;
    wire fast_act;
    wire ramp_act;
    assign coast_act = ~coast_ok;
    assign fast_act  = coast_ok & ~fast_ok;
    assign ramp_act  = coast_ok & fast_ok & ~cw[`DCWD_BIT_RAMP_STOP];

    // =============================================
    // edge detection state
    // the three acknowledge sources share one detector shape,
    // so they are built by one generate loop below
    reg        on_prev_r;      // previous bit0 after gating
    reg        on_armed_r;     // on edge seen, not yet stopped
    wire [2:0] ack_lvl;        // ack levels: bit7, source b, source c
    wire [2:0] ack_edge;       // one rising edge flag per ack source

    wire on_rise;
    wire ack_rise;
    // history starts low, so a word with bit0 high right after reset
    // counts as a switch-on edge; the idle word keeps bit0 low
    assign on_rise  = cw[`DCWD_BIT_RAMP_STOP] & ~on_prev_r;
    // bit7 comes through the host gate, the other two come straight in
    assign ack_lvl  = {fault_ack_source_c,
                       fault_ack_source_b,
                       cw[`DCWD_BIT_FAULT_ACK]};
    // only edges acknowledge, static levels do nothing
    assign ack_rise = |ack_edge;

    // bit0 history for the switch-on edge
    always @(posedge clk_sys) begin
        if (reset) begin
            on_prev_r <= 1'b0;                  // idle level of bit0
        end else begin
            on_prev_r <= cw[`DCWD_BIT_RAMP_STOP];
        end
    end

    // one detector per acknowledge source
    // history resets low, the idle level of every source
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_ack
            reg ack_prev_r;   // level seen on the previous edge
            // remember the level for the next compare
            always @(posedge clk_sys) begin
                if (reset) begin
                    ack_prev_r <= 1'b0;
                end else begin
                    ack_prev_r <= ack_lvl[gi];
                end
            end
            // low then high: one acknowledge request
            assign ack_edge[gi] = ack_lvl[gi] & ~ack_prev_r;
        end
    endgenerate

    // on latch: armed by a rising bit0, dropped by any stop
    // a stop wins over a switch-on edge in the same cycle, so a word
    // that raises bit0 while a stop source is low never arms
    // rearming needs bit0 to go low and high again after the stop
    reg on_armed_nxt;
    always @* begin
        on_armed_nxt = on_armed_r;
        if (coast_act | fast_act | ramp_act) begin
            on_armed_nxt = 1'b0;
        end else if (on_rise) begin
            on_armed_nxt = 1'b1;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            on_armed_r <= 1'b0;
        end else begin
            on_armed_r <= on_armed_nxt;
        end
    end

    // =============================================
    // potentiometer and command set, reserved unless the telegram gives them
    // in other telegrams bits 13 and 14 read as zero, so the pot stays frozen
    wire pot_en;
    wire up_c;
    wire dn_c;
    assign pot_en = tel_std | tel_pcs;
    assign up_c   = pot_en & cw[`DCWD_BIT_POT_RAISE];
    assign dn_c   = pot_en & cw[`DCWD_BIT_POT_LOWER];

    // setpoint into the ramp: zero unless bit6 is set
    wire signed [15:0] ramp_in;
    assign ramp_in = cw[`DCWD_BIT_SETP_ENABLE] ? spd : `DCWD_RST_SPEED;

    // signed product of setpoint and reference, divided by 16'h4000
    // the reference gets a zero on top so it is never read as negative;
    // 16 by 17 signed bits fit 33 bits, no overflow at full scale
    // after the shift 19 bits remain, sign-extended to the 32-bit output
    // limitation: the low 14 bits are dropped, rounding toward minus infinity
    wire signed [32:0] prod;
    assign prod = spd * $signed({1'b0, reference_speed});

    // =============================================
    // output registers
    // bits 8, 9, 11, 12 are never read, so they touch no state
    // every output is a flip-flop, so the consumer sees no glitch from
    // the gating and priority logic above
    always @(posedge clk_sys) begin
        if (reset) begin
            // reset is a safe state: coast stop held, ramp held at zero,
            // nothing enabled, pot frozen
            ramp_stop_command   <= 1'b0;
            coast_stop_command  <= 1'b1;    // pulses off during reset
            fast_stop_command   <= 1'b0;
            switch_on_edge      <= 1'b0;
            pulse_enable        <= 1'b0;
            contactor_close     <= 1'b0;
            ready_for_operation <= 1'b0;
            // ramp generator held at zero and frozen
            ramp_force_zero     <= 1'b1;
            ramp_freeze         <= 1'b1;
            ramp_input_zero     <= 1'b1;
            ramp_setpoint       <= `DCWD_RST_SPEED;
            speed_scaled        <= 32'h00000000;
            fault_ack           <= 1'b0;
            pot_raise           <= 1'b0;
            pot_lower           <= 1'b0;
            pot_freeze          <= 1'b1;    // neither raise nor lower
            command_set_select  <= 1'b0;    // command set 0
            host_control_active <= 1'b0;    // bus ignored until gated
        end else begin
            // stop commands after priority
            coast_stop_command  <= coast_act;
            fast_stop_command   <= fast_act;
            ramp_stop_command   <= ramp_act;
            switch_on_edge      <= on_rise;
            // contactor closed while armed; any stop, coast, fast or ramp, opens it at once
            contactor_close     <= on_armed_nxt;
            ready_for_operation <= on_armed_nxt;
            // pulses need on, bit3 and no stop; bit3 low keeps ready set
            pulse_enable        <= on_armed_nxt & cw[`DCWD_BIT_ENABLE_OP];
            // ramp generator controls, each active while its bit is low
            // force zero and freeze may both be set; the consumer gives
            // force zero the upper hand
            ramp_force_zero     <= ~cw[`DCWD_BIT_RAMP_ENABLE];
            ramp_freeze         <= ~cw[`DCWD_BIT_RAMP_RUN];
            ramp_input_zero     <= ~cw[`DCWD_BIT_SETP_ENABLE];
            ramp_setpoint       <= ramp_in;
            // scaled speed follows the gated setpoint even when bit6 is low
            speed_scaled        <= {{13{prod[32]}}, prod[32:`DCWD_SCALE_SHIFT]};
            // acknowledge pulse, one cycle per edge
            fault_ack           <= ack_rise;
            // pot: equal levels freeze
            // raise and lower can never both be high at the output
            pot_raise           <= up_c & ~dn_c;
            pot_lower           <= dn_c & ~up_c;
            pot_freeze          <= ~(up_c ^ dn_c);
            command_set_select  <= tel_namur & cw[`DCWD_BIT_CMD_SET0];
            host_control_active <= host_ok;
        end
    end
endmodule // dcwd_decoder

// ### dv/dcwd_chk.sv
// dcwd_chk.sv: port assertions for the drive control word decoder
// assumes: bound to dcwd_decoder; one clock, sync active-high reset
`include "dcwd_consts.vh"
module dcwd_chk (
    // clock, reset and inputs
    input wire        clk_sys, reset, pd_valid, coast_stop_source_b, fault_ack_source_b,
    input wire [15:0] pd_word1,
    input wire [9:0]  telegram_selector,
    // decoded outputs
    input wire        ramp_stop_command, coast_stop_command, fast_stop_command, pulse_enable,
    input wire        ramp_force_zero, ramp_freeze, ramp_input_zero, fault_ack,
    input wire        pot_raise, pot_lower, command_set_select,
    input wire signed [15:0] ramp_setpoint
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // =============================================
    // steps: quiet bus after a load, ack edge, single pulse
    sequence s_quiet; !pd_valid [*3]; endsequence
    sequence s_ack_rise; $rose(fault_ack_source_b); endsequence
    sequence s_one_pulse; fault_ack ##1 !fault_ack; endsequence
    // =============================================
    // properties
    property p_excl; (coast_stop_command || fast_stop_command) |->
        !ramp_stop_command && !(coast_stop_command && fast_stop_command); endproperty
    property p_force; pd_valid && !pd_word1[4] ##1 s_quiet |-> ramp_force_zero; endproperty
    property p_freeze; pd_valid && !pd_word1[5] ##1 s_quiet |-> ramp_freeze; endproperty
    property p_inzero; ramp_input_zero |-> ramp_setpoint == 16'h0000; endproperty
    property p_ack; s_ack_rise |-> ##[1:2] s_one_pulse; endproperty
    property p_ack_pulse; fault_ack |=> !fault_ack; endproperty
    property p_css; command_set_select |-> $past(telegram_selector) == `DCWD_TEL_NAMUR
        || $past(telegram_selector, 2) == `DCWD_TEL_NAMUR; endproperty
    property p_pot; (pot_raise || pot_lower) |-> !(pot_raise && pot_lower) &&
        ($past(telegram_selector) inside {`DCWD_TEL_STD, `DCWD_TEL_PCS}); endproperty
    property p_pulse; pulse_enable |-> !coast_stop_command && !fast_stop_command; endproperty
    property p_coast; !coast_stop_source_b |-> ##[1:2] coast_stop_command; endproperty
    // =============================================
    // assertions
    a_excl: assert property (p_excl) else $error("two stop commands at once");
    a_force: assert property (p_force) else $error("ramp output not forced to zero");
    a_freeze: assert property (p_freeze) else $error("ramp output not frozen");
    a_inzero: assert property (p_inzero) else $error("ramp input not zero");
    a_ack: assert property (p_ack) else $error("source edge gave no ack pulse");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
    a_css: assert property (p_css) else $error("command set outside telegram 20");
    a_pot: assert property (p_pot) else $error("pot command in wrong telegram");
    a_pulse: assert property (p_pulse) else $error("pulses on during stop");
    a_coast: assert property (p_coast) else $error("second source gave no coast stop");
endmodule // dcwd_chk

// ### dv/dcwd_master.sv
// dcwd_master.sv: fieldbus master model sending cyclic word pairs
// assumes: clk_sys shared with the decoder; send is called by the bench
module dcwd_master (
    // clock and drive readiness
    input wire          clk_sys,
    input wire          status_ok,
    // process data words toward the drive
    output logic        pd_valid,
    output logic [15:0] pd_word1,
    output logic [15:0] pd_word2
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pd_valid = 1'b0;
        pd_word1 = 16'h0000;
        pd_word2 = 16'h0000;
    end
    // one pair per call; words scrambled once no longer qualified
    task automatic send(input [15:0] w1, w2);
        @(posedge clk_sys);
        pd_valid <= 1'b1;
        pd_word1 <= status_ok ? w1 : (w1 & 16'hfbff);
        pd_word2 <= w2;
        @(posedge clk_sys);
        pd_valid <= 1'b0;
        pd_word1 <= ~pd_word1;
        pd_word2 <= ~pd_word2;
    endtask
endmodule // dcwd_master

// ### dv/tb_top.sv
// tb_top.sv: self-checking bench for the drive control word decoder
// assumes: dcwd_master drives the words; dcwd_chk is bound below
`include "dcwd_consts.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] REF_SPD = 16'h1000; // reference speed
    logic        clk_sys, reset, cs_b, fs_b, fa_b, fa_c, hsrc;
    logic [9:0]  tel;
    wire         pdv, rs, cs, fs, son, pe, cc, rdy, fz, frz, iz, fa, pr, pl, pf, css, hca;
    wire [15:0]  w1, w2;
    wire signed [15:0] rsp;
    wire signed [31:0] spd;
    int          err_total, num_checks;
    // rows: control word, setpoint word, telegram
    logic [47:0] rows [8] = '{48'h047f_4000_0001, 48'h247e_c000_0160, 48'h4405_2000_0001,
        48'h8403_1234_0014, 48'h6f3f_2000_0001, 48'hfc7f_7fff_03e7, 48'h847f_8000_0014,
        48'h847f_0100_0160};
    dcwd_master dcwd_master_inst (.clk_sys(clk_sys), .status_ok(1'b1), .pd_valid(pdv),
        .pd_word1(w1), .pd_word2(w2));
    dcwd_decoder dcwd_decoder_inst (.clk_sys(clk_sys), .reset(reset), .pd_valid(pdv),
        .pd_word1(w1), .pd_word2(w2), .telegram_selector(tel), .reference_speed(REF_SPD),
        .coast_stop_source_b(cs_b), .fast_stop_source_b(fs_b), .fault_ack_source_b(fa_b),
        .fault_ack_source_c(fa_c), .host_control_source(hsrc), .ramp_stop_command(rs),
        .coast_stop_command(cs), .fast_stop_command(fs), .switch_on_edge(son),
        .pulse_enable(pe), .contactor_close(cc), .ready_for_operation(rdy),
        .ramp_force_zero(fz), .ramp_freeze(frz), .ramp_input_zero(iz), .ramp_setpoint(rsp),
        .speed_scaled(spd), .fault_ack(fa), .pot_raise(pr), .pot_lower(pl), .pot_freeze(pf),
        .command_set_select(css), .host_control_active(hca));
    // expected outputs worked out from the word meanings
    function automatic [58:0] exp_of(input [15:0] w, s, input [9:0] t);
        reg [15:0] e;
        reg v;
        e = w[10] ? w : 16'h0006;
        v = (t == `DCWD_TEL_STD) || (t == `DCWD_TEL_PCS);
        exp_of = {e[6] ? s : 16'h0000, ($signed({{16{s[15]}}, s}) * $signed({16'h0000, REF_SPD})) >>> 14,
            ~e[1], ~e[2] & e[1], ~e[0] & e[1] & e[2], ~e[4], ~e[5], ~e[6],
            e[15] & (t == `DCWD_TEL_NAMUR), v & e[13] & ~e[14], v & e[14] & ~e[13], e[13] == e[14], w[10]};
    endfunction
    task automatic chk(input [58:0] a, e);
        num_checks++;
        if (a !== e) begin
            $display("ERROR t=%0t got %h exp %h", $time, a, e);
            err_total++;
        end
    endtask
    task automatic go(input [15:0] a, b);
        dcwd_master_inst.send(a, b);
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    // one-cycle pulse: seen within four cycles, gone the next
    task automatic pulse_chk(input bit k);
        int n;
        n = 0;
        #1;
        while (n < 4 && (k ? fa : son) !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(n < 4, 1);
        @(posedge clk_sys);
        #1;
        chk(k ? fa : son, 0);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk_sys = 0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        err_total++;
        close_out();
    end
    initial begin
        {reset, cs_b, fs_b, fa_b, fa_c, hsrc, tel} = {6'b111001, 10'h001};
        repeat (6) @(posedge clk_sys);
        #1;
        chk({cs, fz, frz, iz, pe, fa, pf}, 7'h79);
        @(posedge clk_sys) reset <= 0;
        for (int i = 0; i < 8; i++) begin
            bit m;
            @(posedge clk_sys) tel <= rows[i][9:0];
            go(rows[i][47:32], rows[i][31:16]);
            m = !(tel == `DCWD_TEL_STD || tel == `DCWD_TEL_PCS);
            chk({rsp, spd, cs, fs, rs, fz, frz, iz, css, pr, pl, pf | m, hca},
                exp_of(rows[i][47:32], rows[i][31:16], tel) | {m, 1'b0});
        end
        $display("table done");
        go(16'h0476, 16'h1000);
        chk(rs, 1);
        dcwd_master_inst.send(16'h047f, 16'h1000);
        pulse_chk(0);
        chk({pe, cc, rdy}, 3'h7);
        go(16'h0477, 16'h1000);
        chk({pe, rdy}, 2'h1);
        go(16'h047f, 16'h1000);
        @(posedge clk_sys) {cs_b, fs_b} <= 2'b00;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({cs, fs, rs, pe, cc}, 5'h10);
        @(posedge clk_sys) cs_b <= 1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({cs, fs, pe}, 3'h2);
        @(posedge clk_sys) fs_b <= 1;
        go(16'h047f, 16'h1000);
        chk(pe, 0);
        $display("stops done");
        dcwd_master_inst.send(16'h04ff, 16'h1000);
        pulse_chk(1);
        @(posedge clk_sys) fa_b <= 1;
        pulse_chk(1);
        @(posedge clk_sys) fa_c <= 1;
        pulse_chk(1);
        $display("ack done");
        go(16'h007f, 16'h4000);
        chk({rsp, hca, pe}, 0);
        @(posedge clk_sys) hsrc <= 0;
        go(16'h047f, 16'h4000);
        chk({rsp, hca}, 0);
        $display("gate done");
        // reset in mid-run: safe state, then a fresh switch-on
        @(posedge clk_sys) reset <= 1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({cs, fz, frz, iz, pe, fa, pf, rsp, spd}, {7'h79, 48'h0});
        @(posedge clk_sys) {reset, hsrc} <= 2'b01;
        go(16'h047f, 16'h1000);
        chk({pe, cc, rdy, hca, rsp}, {4'hf, 16'h1000});
        $display("reset done");
        close_out();
    end
endmodule // tb_top
bind dcwd_decoder dcwd_chk dcwd_chk_inst (.*);
